/* hw/htp_device.sv */
// Device end: shared host/test port, reset pin and lock select control
// Function
// - Strap high selects test port, low host
// - All serial bits move on shared clock
// - Host writes address and data via input
// - Device returns register contents on output
// - Select low addresses device in host mode
// - Select acts as TMS in test mode
// - Input is TDI, output TDO in test
// - Reset low: defaults, tri-state, clocks low
// - Reset high resumes from default settings
// - System holds reset low 500 us
// - Test mode reset clears registers and TAP
// - Reset release lets TAP run again
// - Locked only when select low and lock achieved
// - Select high: clocks and timing free-run
// - Audio clocks always follow video clock
// - Without reference, outputs follow internal defaults
`timescale 1ns/10ps
`default_nettype none
module htp_device #(
  parameter int NREG = htp_pkg::NUM_REGS
) (
  input  wire logic   clk,             // Internal core clock
  input  wire logic   srst,            // Core synchronous reset
  input  wire logic   ce,              // Core clock enable
  htp_link_if.device  link,            // Shared pins, link clocked
  input  wire logic   lockSelN,        // Lock select pin, low = lock
  input  wire logic   refPresent,      // Reference detected (core)
  input  wire logic   lockAchieved,    // Locking succeeded (core)
  output logic        lockedMode,      // Reference-locked mode
  output logic        freeRun,         // Free-running mode
  output logic        audioFollowVideo,// Audio clocks track video
  output logic        videoClkEnable,  // Video clocks a/b may run
  output logic        outputsEnable,   // Other pins may drive
  output logic        coreReset,       // Functional blocks in reset
  output logic [15:0] ctrlWord         // Register 0 seen by core
);
  // ----------------------------------------------------------------
  // Link domain state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [htp_pkg::FRAME_W-1:0] shift;   // Incoming frame bits
    logic [htp_pkg::CNT_W-1:0]   cnt;     // Bits received
    logic [15:0]                 outSh;   // Read data shifter
    logic                        rdAct;   // Read data phase
    logic [NREG-1:0][15:0]       regs;    // Host registers
    htp_pkg::htp_tap_t           tap;     // TAP state
    logic [3:0]                  ir;      // Instruction register
    logic [15:0]                 dr;      // Data (bypass/scan) reg
    logic                        tdo;     // Test data out
    logic                        tdoOe;   // Test out enable
    logic                        upd;     // Toggles on each landed write
  } htp_lnk_t;

  htp_lnk_t lq, ld;  // Link state and next value
  logic lnkRstN;     // Synchronised reset pin (link)
  logic lnkTest;     // Synchronised strap (link)
  logic lstat;       // Synchronised lock status into link

  htp_sync2 #(.INIT(1'b0)) uLnkRst (
    .clk(link.serialClockSharedPin), .srst(1'b0), .ce(1'b1),
    .din(link.resetN), .dout(lnkRstN));
  htp_sync2 #(.INIT(1'b0)) uLnkMode (
    .clk(link.serialClockSharedPin), .srst(1'b0), .ce(1'b1),
    .din(link.testModeSel), .dout(lnkTest));
  htp_sync2 #(.INIT(1'b0)) uLnkStat (
    .clk(link.serialClockSharedPin), .srst(1'b0), .ce(1'b1),
    .din(lockedMode), .dout(lstat));

  // TAP next-state function on TMS
  function automatic htp_pkg::htp_tap_t tapNext(
    input htp_pkg::htp_tap_t s, input logic tms);
    case (s)
      htp_pkg::TAP_RESET:   tapNext = tms ? htp_pkg::TAP_RESET
                                          : htp_pkg::TAP_IDLE;
      htp_pkg::TAP_IDLE:    tapNext = tms ? htp_pkg::TAP_DRSEL
                                          : htp_pkg::TAP_IDLE;
      htp_pkg::TAP_DRSEL:   tapNext = tms ? htp_pkg::TAP_IRSEL
                                          : htp_pkg::TAP_DRCAP;
      htp_pkg::TAP_DRCAP,
      htp_pkg::TAP_DRSHIFT: tapNext = tms ? htp_pkg::TAP_DREX1
                                          : htp_pkg::TAP_DRSHIFT;
      htp_pkg::TAP_DREX1:   tapNext = tms ? htp_pkg::TAP_DRUPD
                                          : htp_pkg::TAP_DRPAUSE;
      htp_pkg::TAP_DRPAUSE: tapNext = tms ? htp_pkg::TAP_DREX2
                                          : htp_pkg::TAP_DRPAUSE;
      htp_pkg::TAP_DREX2:   tapNext = tms ? htp_pkg::TAP_DRUPD
                                          : htp_pkg::TAP_DRSHIFT;
      htp_pkg::TAP_IRSEL:   tapNext = tms ? htp_pkg::TAP_RESET
                                          : htp_pkg::TAP_IRCAP;
      htp_pkg::TAP_IRCAP,
      htp_pkg::TAP_IRSHIFT: tapNext = tms ? htp_pkg::TAP_IREX1
                                          : htp_pkg::TAP_IRSHIFT;
      htp_pkg::TAP_IREX1:   tapNext = tms ? htp_pkg::TAP_IRUPD
                                          : htp_pkg::TAP_IRPAUSE;
      htp_pkg::TAP_IRPAUSE: tapNext = tms ? htp_pkg::TAP_IREX2
                                          : htp_pkg::TAP_IRPAUSE;
      htp_pkg::TAP_IREX2:   tapNext = tms ? htp_pkg::TAP_IRUPD
                                          : htp_pkg::TAP_IRSHIFT;
      htp_pkg::TAP_DRUPD,
      htp_pkg::TAP_IRUPD:   tapNext = tms ? htp_pkg::TAP_DRSEL
                                          : htp_pkg::TAP_IDLE;
      default:              tapNext = htp_pkg::TAP_RESET;
    endcase
  endfunction

  // Link next-state logic
  always_comb begin
    logic [htp_pkg::ADDR_W-1:0] a;
    logic [15:0]                rdv;
    a   = '0;
    rdv = '0;
    ld  = lq;
    ld.tdoOe = 1'b0;
    if (!lnkRstN) begin
      ld = '0;
      ld.tap = htp_pkg::TAP_RESET;
    end else if (lnkTest) begin
      // Test mode: select pin is TMS, input TDI, output TDO
      ld.tap = tapNext(lq.tap, link.selectSharedPin);
      case (lq.tap)
        htp_pkg::TAP_DRCAP: ld.dr = lq.regs[0];
        htp_pkg::TAP_DRSHIFT: begin
          ld.dr    = {link.serialInSharedPin, lq.dr[15:1]};
          ld.tdo   = lq.dr[0];
          ld.tdoOe = 1'b1;
        end
        htp_pkg::TAP_IRCAP: ld.ir = 4'h1;
        htp_pkg::TAP_IRSHIFT: begin
          ld.ir    = {link.serialInSharedPin, lq.ir[3:1]};
          ld.tdo   = lq.ir[0];
          ld.tdoOe = 1'b1;
        end
        default: ld.tdo = 1'b0;
      endcase
    end else if (link.selectSharedPin) begin
      // Deselected: frame restarts
      ld.cnt   = '0;
      ld.rdAct = 1'b0;
    end else begin
      // Host mode: shift frame on the serial clock
      ld.shift = {lq.shift[htp_pkg::FRAME_W-2:0],
                  link.serialInSharedPin};
      ld.cnt   = lq.cnt + 1'b1;
      a = ld.shift[htp_pkg::ADDR_LSB +: htp_pkg::ADDR_W];
      if (lq.cnt == htp_pkg::CNT_W'(htp_pkg::ADDR_W)) begin
        // Read flag and address complete: load read data
        a   = {lq.shift[htp_pkg::ADDR_W-2:0], link.serialInSharedPin};
        rdv = (a == htp_pkg::STATUS_ADDR) ? {15'h0000, lstat}
            : (a < NREG[7:0]) ? lq.regs[a[2:0]] : 16'h0000;
        ld.rdAct = lq.shift[htp_pkg::ADDR_W-1];
        ld.outSh = rdv;
      end else if (lq.rdAct) begin
        ld.outSh = {lq.outSh[14:0], 1'b0};
      end
      if (lq.cnt == htp_pkg::CNT_W'(htp_pkg::FRAME_W - 1)) begin
        if (!ld.shift[htp_pkg::RW_POS] && a < NREG[7:0]) begin
          ld.regs[a[2:0]] = ld.shift[15:0];
          ld.upd          = !lq.upd;
        end
        ld.cnt   = '0;
        ld.rdAct = 1'b0;
      end
    end
  end

  // Link registers
  always_ff @(posedge link.serialClockSharedPin) begin
    lq <= ld;
  end

  // Output pin: driven only when reading or shifting TDO
  assign link.serialOutDrv = lnkTest ? lq.tdo : lq.outSh[15];
  assign link.serialOutOe  = lnkTest ? lq.tdoOe
                                     : (lq.rdAct & lnkRstN);

  // ----------------------------------------------------------------
  // Core domain
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        locked;
    logic        free;
    logic        vclk;
    logic        oen;
    logic        crst;
    logic [15:0] ctrl;
    logic        updSeen;  // Last write toggle taken over
  } htp_core_t;

  htp_core_t cq, cd;   // Core state and next value
  logic coreRstN;      // Synchronised reset pin
  logic lockSelS;      // Synchronised lock select
  logic updS;          // Synchronised link write toggle

  htp_sync2 #(.INIT(1'b0)) uCoreRst (
    .clk(clk), .srst(srst), .ce(ce),
    .din(link.resetN), .dout(coreRstN));
  htp_sync2 #(.INIT(1'b1)) uCoreLock (
    .clk(clk), .srst(srst), .ce(ce),
    .din(lockSelN), .dout(lockSelS));
  // Only the write toggle crosses bit by bit; the word follows it
  htp_sync2 #(.INIT(1'b0)) uCoreUpd (
    .clk(clk), .srst(srst), .ce(ce),
    .din(lq.upd), .dout(updS));

  // Mode decisions
  always_comb begin
    cd = cq;
    cd.crst   = !coreRstN;
    cd.vclk   = coreRstN;
    cd.oen    = coreRstN;
    cd.locked = coreRstN && !lockSelS && refPresent
                && lockAchieved;
    cd.free   = !cd.locked;
    // Word taken once its toggle has crossed: all bits long settled
    cd.updSeen = updS;
    cd.ctrl    = !coreRstN ? htp_pkg::REG_RESET
               : (updS != cq.updSeen) ? lq.regs[0] : cq.ctrl;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cq <= '0;
      cq.free <= 1'b1;
    end else if (ce) begin
      cq <= cd;
    end
  end

  assign lockedMode       = cq.locked;
  assign freeRun          = cq.free;
  assign audioFollowVideo = 1'b1;
  assign videoClkEnable   = cq.vclk;
  assign outputsEnable    = cq.oen;
  assign coreReset        = cq.crst;
  assign ctrlWord         = cq.ctrl;
endmodule
`default_nettype wire

/* hw/htp_host.sv */
// Host end: drives shared pins, serial frames and reset pin
`timescale 1ns/10ps
`default_nettype none
module htp_host #(
  parameter int HOLD_CYC = htp_pkg::RESET_HOLD_CYC
) (
  input  wire logic   clk,        // Host clock
  input  wire logic   srst,       // Synchronous reset
  input  wire logic   ce,         // Clock enable
  htp_link_if.host    link,       // Shared pins
  input  wire logic   testMode,   // Strap level to drive
  input  wire logic   reqValid,   // Start a host frame
  input  wire logic   reqRead,    // 1 = read, 0 = write
  input  wire logic [7:0]  reqAddr,   // Register address
  input  wire logic [15:0] reqData,   // Write data
  output logic        busy,       // Frame or reset in progress
  output logic        rspValid,   // One-cycle pulse: frame done
  output logic [15:0] rspData     // Read data
);
  // Reset pin release point: the longer of hold time and clock run
  localparam int REL_CYC = (HOLD_CYC > htp_pkg::RST_EDGE_CYC)
                         ? HOLD_CYC : htp_pkg::RST_EDGE_CYC;

  typedef enum logic [1:0] {H_RST, H_IDLE, H_SHIFT, H_GAP} htp_hst_t;
  typedef struct packed {
    htp_hst_t    st;
    logic [31:0] hold;     // Reset hold counter
    logic [24:0] frame;    // Outgoing bits
    logic [4:0]  bits;     // Bits sent
    logic [2:0]  div;      // Clock divider
    logic        sclk;     // Serial clock level
    logic        csN;      // Chip select
    logic        rstN;     // Reset pin level
    logic        mode;     // Strap level
    logic [15:0] rd;       // Read capture
    logic        done;     // Response pulse
  } htp_host_state_t;

  htp_host_state_t q, d;
  logic sdoS;  // Synchronised serial output

  htp_sync2 #(.INIT(1'b0)) uSdo (
    .clk(clk), .srst(srst), .ce(ce),
    .din(link.serialOutSharedPin), .dout(sdoS));

  // Frame sequencer; clock edges made by divider
  always_comb begin
    d = q;
    d.done = 1'b0;
    d.mode = testMode;
    case (q.st)
      H_RST: begin
        // Hold reset low for the required time. The link clock runs
        // so that the device's link side sees the low level and,
        // after release, the high level before the first frame.
        d.hold = q.hold + 32'h0000_0001;
        d.div  = q.div + 3'h1;
        if (q.div == 3'(htp_pkg::SCLK_HALF - 1)) begin
          d.div  = '0;
          d.sclk = !q.sclk;
        end
        d.rstN = (q.hold >= 32'(REL_CYC));
        // Leave only with the clock low and no toggle pending
        if (q.hold >= 32'(REL_CYC + htp_pkg::RST_EDGE_CYC)
            && !q.sclk && q.div != 3'(htp_pkg::SCLK_HALF - 1)) begin
          d.div = '0;
          d.st  = H_IDLE;
        end
      end
      H_IDLE: begin
        d.csN = 1'b1;
        if (reqValid) begin
          d.frame = {reqRead, reqAddr, reqData};
          d.bits  = '0;
          d.div   = '0;
          d.csN   = 1'b0;
          d.st    = H_SHIFT;
        end
      end
      H_SHIFT: begin
        d.div = q.div + 3'h1;
        if (q.div == 3'(htp_pkg::SCLK_HALF - 1)) begin
          d.div  = '0;
          d.sclk = !q.sclk;
          if (q.sclk) begin
            // Falling edge: next bit out
            d.frame = {q.frame[23:0], 1'b0};
            d.bits  = q.bits + 5'h01;
            if (q.bits == 5'(htp_pkg::FRAME_W - 1))
              d.st = H_GAP;
          end else if (q.bits > 5'(htp_pkg::ADDR_W)) begin
            d.rd = {q.rd[14:0], sdoS};
          end
        end
      end
      H_GAP: begin
        d.csN  = 1'b1;
        d.done = 1'b1;
        d.st   = H_IDLE;
      end
      default: d.st = H_RST;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
      q.csN <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  assign link.serialClockSharedPin = q.sclk;
  assign link.serialInSharedPin    = q.frame[24];
  assign link.selectSharedPin      = q.csN;
  assign link.resetN               = q.rstN;
  assign link.testModeSel          = q.mode;
  assign busy     = (q.st != H_IDLE);
  assign rspValid = q.done;
  assign rspData  = q.rd;
endmodule
`default_nettype wire

/* hw/htp_link_if.sv */
// Interface carrying the shared serial pins between host and device
`timescale 1ns/10ps
`default_nettype none
interface htp_link_if;
  logic serialClockSharedPin;  // Shared serial / test clock
  logic serialInSharedPin;     // Host to device data
  logic serialOutSharedPin;    // Device to host data (pin value)
  logic serialOutDrv;          // Device drive value
  logic serialOutOe;           // Device output enable
  logic selectSharedPin;       // Chip select low / test mode select
  logic resetN;                // Reset pin, active low
  logic testModeSel;           // Strap: high selects test port

  // Pin level: undriven output reads low here
  assign serialOutSharedPin = serialOutOe & serialOutDrv;

  modport device (
    input  serialClockSharedPin, serialInSharedPin, selectSharedPin,
    input  resetN, testModeSel,
    output serialOutDrv, serialOutOe
  );
  modport host (
    output serialClockSharedPin, serialInSharedPin, selectSharedPin,
    output resetN, testModeSel,
    input  serialOutSharedPin
  );
endinterface
`default_nettype wire

/* hw/htp_pkg.sv */
// Package of shared constants and types for the host/test port block
package htp_pkg;

  // Host frame layout: one read/write bit, address, data
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 16;
  localparam int FRAME_W   = 1 + ADDR_W + DATA_W;
  localparam int CNT_W     = 5;
  localparam int NUM_REGS  = 8;

  // Field positions inside the shifted frame
  localparam int RW_POS    = FRAME_W - 1;
  localparam int ADDR_LSB  = DATA_W;

  // Register reset value and status register address
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [7:0]  STATUS_ADDR = 8'h07;

  // Reset hold time on the reset pin, owed by the system
  localparam int RESET_HOLD_US = 500;
  localparam int CLK_MHZ       = 100;
  localparam int RESET_HOLD_CYC = RESET_HOLD_US * CLK_MHZ;

  // Host-side serial clock divider: half period in system clocks
  localparam int SCLK_HALF = 4;

  // Link clock run around a reset release, in system clocks: four link
  // periods, enough for the device's two-flop link synchronisers
  localparam int RST_EDGE_CYC = 8 * SCLK_HALF;

  // Test access port controller states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_DRSEL, TAP_DRCAP, TAP_DRSHIFT, TAP_DREX1,
    TAP_DRPAUSE, TAP_DREX2, TAP_DRUPD, TAP_IRSEL, TAP_IRCAP, TAP_IRSHIFT,
    TAP_IREX1, TAP_IRPAUSE, TAP_IREX2, TAP_IRUPD
  } htp_tap_t;

endpackage

/* hw/htp_sync2.sv */
// Two-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module htp_sync2 #(
  parameter logic INIT = 1'b0
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic din,
  output logic      dout
);
  logic metaQ;  // First stage, read only by second
  logic syncQ;  // Second stage

  // Two-stage capture
  always_ff @(posedge clk) begin
    if (srst) begin
      metaQ <= INIT;
      syncQ <= INIT;
    end else if (ce) begin
      metaQ <= din;
      syncQ <= metaQ;
    end
  end
  assign dout = syncQ;
endmodule
`default_nettype wire

/* sim/htp_link_chk.sv */
// Checker for the shared serial link between the host and device ends
`timescale 1ns/10ps
`default_nettype none
module htp_link_chk #(
  parameter int HOLD_CYC = htp_pkg::RESET_HOLD_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic serialClockSharedPin,
  input wire logic serialInSharedPin,
  input wire logic serialOutSharedPin,
  input wire logic serialOutDrv,
  input wire logic serialOutOe,
  input wire logic selectSharedPin,
  input wire logic resetN,
  input wire logic testModeSel
);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  logic [5:0]  edgeCnt_q;  // Rising link clock edges in this frame
  logic [15:0] lowCnt_q;   // Cycles the reset pin has been held low
  logic [7:0]  relCnt_q;   // Cycles since the reset pin went high

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // Count link clock edges under select and reset-low cycles
  always_ff @(posedge clk) begin
    if (srst) begin
      edgeCnt_q <= 6'h00;
      lowCnt_q  <= 16'h0000;
      relCnt_q  <= 8'h00;
    end else begin
      if (selectSharedPin) begin
        edgeCnt_q <= 6'h00;
      end else if ($rose(serialClockSharedPin)) begin
        edgeCnt_q <= edgeCnt_q + 6'h01;
      end
      if (resetN) begin
        lowCnt_q <= 16'h0000;
      end else if (lowCnt_q != 16'hFFFF) begin
        lowCnt_q <= lowCnt_q + 16'h0001;
      end
      if (!resetN) begin
        relCnt_q <= 8'h00;
      end else if (relCnt_q != 8'hFF) begin
        relCnt_q <= relCnt_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // The link clock runs through a reset and briefly after its release
  chk_sclk_parked: assert property (
    selectSharedPin && !serialClockSharedPin && !testModeSel
    && relCnt_q >= 8'(htp_pkg::RST_EDGE_CYC + 4 * htp_pkg::SCLK_HALF)
    |=> !serialClockSharedPin || !selectSharedPin)
    else $error("Link clock rose with the device deselected");
  chk_sclk_release: assert property (
    $rose(selectSharedPin) |-> ##[0:4] !serialClockSharedPin)
    else $error("Link clock not parked low after a frame");
  chk_sclk_half: assert property (
    $rose(serialClockSharedPin) |-> serialClockSharedPin [*4])
    else $error("Link clock high phase shorter than four cycles");
  chk_frame_start: assert property (
    $fell(selectSharedPin) |-> ##[1:8] $rose(serialClockSharedPin))
    else $error("No link clock edge soon after select fell");
  chk_din_stable: assert property (
    $rose(serialClockSharedPin) |-> $stable(serialInSharedPin))
    else $error("Serial input moved on a rising link clock");
  chk_frame_bits: assert property (
    $rose(selectSharedPin) && !testModeSel
    |-> edgeCnt_q == 6'(htp_pkg::FRAME_W))
    else $error("Frame did not carry the full bit count");
  chk_select_gap: assert property (
    $rose(selectSharedPin) |-> selectSharedPin [*2])
    else $error("Select released for less than two cycles");
  chk_reset_quiet: assert property (
    !resetN |-> selectSharedPin)
    else $error("Device addressed while its reset pin is low");
  chk_reset_hold: assert property (
    $rose(resetN) |-> lowCnt_q >= 16'(HOLD_CYC))
    else $error("Reset pin released before the hold time");
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// Testbench joining the host end and the device end over the link
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int HOLD  = 20;     // Shortened reset hold on the pin
  localparam int LIMIT = 20000;  // Cycle ceiling for the whole run

  logic        clk = 1'h0;       // Core clock, 100 MHz
  logic        srst;             // Synchronous reset of both ends
  logic        testMode;         // Strap level handed to the host
  logic        reqValid;         // Frame request
  logic        reqRead;          // Read when high
  logic [7:0]  reqAddr;          // Register address
  logic [15:0] reqData;          // Write data
  logic        busy;             // Host busy
  logic        rspValid;         // Frame done pulse
  logic [15:0] rspData;          // Read data
  logic        lockSelN;         // Lock select pin, low asks for lock
  logic        refPresent;       // Reference detected
  logic        lockAchieved;     // Locking succeeded
  logic        lockedMode;       // Locked mode flag
  logic        freeRun;          // Free-run flag
  logic        audioFollowVideo; // Audio follows video clock
  logic        videoClkEnable;   // Video clocks may run
  logic        outputsEnable;    // Other pins may drive
  logic        coreReset;        // Functional blocks in reset
  logic [15:0] ctrlWord;         // Register 0 as seen by the core
  int          n_mismatch = 0;   // Mismatches seen
  int          n_compared = 0;   // Comparisons made
  int          cycles = 0;       // Cycle count for the ceiling

  // Clock generator
  always #5 clk = ~clk;

  htp_link_if link ();

  htp_host #(.HOLD_CYC(HOLD)) htp_host_i (
    .clk(clk), .srst(srst), .ce(1'h1), .link(link.host),
    .testMode(testMode), .reqValid(reqValid), .reqRead(reqRead),
    .reqAddr(reqAddr), .reqData(reqData), .busy(busy),
    .rspValid(rspValid), .rspData(rspData));

  htp_device htp_device_i (
    .clk(clk), .srst(srst), .ce(1'h1), .link(link.device),
    .lockSelN(lockSelN), .refPresent(refPresent),
    .lockAchieved(lockAchieved), .lockedMode(lockedMode),
    .freeRun(freeRun), .audioFollowVideo(audioFollowVideo),
    .videoClkEnable(videoClkEnable), .outputsEnable(outputsEnable),
    .coreReset(coreReset), .ctrlWord(ctrlWord));

  htp_link_chk #(.HOLD_CYC(HOLD)) htp_link_chk_i (
    .clk(clk), .srst(srst),
    .serialClockSharedPin(link.serialClockSharedPin),
    .serialInSharedPin(link.serialInSharedPin),
    .serialOutSharedPin(link.serialOutSharedPin),
    .serialOutDrv(link.serialOutDrv), .serialOutOe(link.serialOutOe),
    .selectSharedPin(link.selectSharedPin), .resetN(link.resetN),
    .testModeSel(link.testModeSel));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Compare one value and count the outcome
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One host frame; waits for the done pulse under a bound
  task automatic xfer(logic rd, logic [7:0] a, logic [15:0] d);
    int n;
    @(posedge clk);
    reqValid <= 1'h1;
    reqRead  <= rd;
    reqAddr  <= a;
    reqData  <= d;
    @(posedge clk);
    reqValid <= 1'h0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rspValid !== 1'h1 && n < 400);
    chk("frame done", 16'h0001, {15'h0000, rspValid});
  endtask

  // Wait a bounded time for a level to reach a value
  task automatic settle(ref logic s, input logic exp);
    int n;
    n = 0;
    while (s !== exp && n < 200) begin
      @(negedge clk);
      n++;
    end
  endtask

  // Closing report
  task automatic end_sim;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Ceiling on the run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_mismatch++;
      $display("CHECK FAILED run length expected below %0d", LIMIT);
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    srst = 1'h1;
    testMode = 1'h0;
    reqValid = 1'h0;
    reqRead = 1'h0;
    reqAddr = 8'h00;
    reqData = 16'h0000;
    lockSelN = 1'h1;
    refPresent = 1'h0;
    lockAchieved = 1'h0;
    repeat (10) @(posedge clk);
    chk("free run in reset", 16'h0001, {15'h0000, freeRun});
    chk("locked in reset", 16'h0000, {15'h0000, lockedMode});
    repeat (10) @(posedge clk);
    srst <= 1'h0;
    @(negedge clk);
    chk("reset pin", 16'h0000, {15'h0000, link.resetN});
    repeat (3) @(negedge clk);
    chk("core reset held", 16'h0001, {15'h0000, coreReset});
    chk("outputs off", 16'h0000, {15'h0000, outputsEnable});
    chk("video clocks low", 16'h0000, {15'h0000, videoClkEnable});
    chk("control in reset", 16'h0000, ctrlWord);
    settle(busy, 1'h0);
    chk("host idle", 16'h0000, {15'h0000, busy});
    // Write to an unmapped address first; it must change nothing
    xfer(1'h0, 8'h08, 16'hFFFF);
    for (int i = 0; i < 7; i++) begin
      xfer(1'h0, 8'(i), 16'h5A00 + 16'(i));
    end
    for (int i = 0; i < 7; i++) begin
      xfer(1'h1, 8'(i), 16'h0000);
      chk("read back", 16'h5A00 + 16'(i), rspData);
    end
    xfer(1'h1, 8'h08, 16'h0000);
    chk("unmapped read", 16'h0000, rspData);
    chk("control word", 16'h5A00, ctrlWord);
    settle(coreReset, 1'h0);
    chk("core reset", 16'h0000, {15'h0000, coreReset});
    chk("outputs on", 16'h0001, {15'h0000, outputsEnable});
    chk("video clocks", 16'h0001, {15'h0000, videoClkEnable});
    xfer(1'h1, 8'h07, 16'h0000);
    chk("status free", 16'h0000, rspData);
    // Lock asked for with a reference but lock not yet achieved
    @(posedge clk);
    refPresent <= 1'h1;
    @(posedge clk);
    lockSelN <= 1'h0;
    settle(lockedMode, 1'h1);
    chk("lock too early", 16'h0000, {15'h0000, lockedMode});
    @(posedge clk);
    lockAchieved <= 1'h1;
    settle(lockedMode, 1'h1);
    chk("locked", 16'h0001, {15'h0000, lockedMode});
    chk("audio locked", 16'h0001, {15'h0000, audioFollowVideo});
    xfer(1'h1, 8'h07, 16'h0000);
    chk("status locked", 16'h0001, rspData);
    // Select high again: free run whatever the lock state
    @(posedge clk);
    lockSelN <= 1'h1;
    settle(freeRun, 1'h1);
    chk("free run", 16'h0001, {15'h0000, freeRun});
    chk("unlocked", 16'h0000, {15'h0000, lockedMode});
    chk("audio free", 16'h0001, {15'h0000, audioFollowVideo});
    // Second reset in mid-run: registers return to their defaults
    @(posedge clk);
    srst <= 1'h1;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    settle(busy, 1'h0);
    chk("idle after reset", 16'h0000, {15'h0000, busy});
    chk("control default", 16'h0000, ctrlWord);
    xfer(1'h1, 8'h00, 16'h0000);
    chk("register default", 16'h0000, rspData);
    end_sim();
  end
endmodule
`default_nettype wire
